// *** verilog/brc_regs.vh ***
// brc_regs.vh: offsets, field positions, reset values and timing constants
// for the reset, power-state and clock-control block of the bridge.
// assumes: included by bare name from the block's design files.
`ifndef BRC_REGS_VH
`define BRC_REGS_VH

// ------------------------------------------------------------
// register byte offsets of the configuration space
// ------------------------------------------------------------
`define BRC_OFF_BRIDGE_CTL 8'h3C
`define BRC_OFF_CHIP_CTL 8'h40
`define BRC_OFF_CLKRUN_CTL 8'h58
`define BRC_OFF_DSCLK_CTL 8'h68
`define BRC_OFF_PM_CAP 8'hDC
`define BRC_OFF_PM_DATA 8'hE0

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
// bridge control: downstream bus reset bit (upper half of dword)
`define BRC_BIT_DS_RESET 22
// chip control: chip reset bit
`define BRC_BIT_CHIP_RESET 0
// clock-run control fields
`define BRC_BIT_KEEP_CLK 0
`define BRC_BIT_DS_CLKRUN_EN 1
`define BRC_BIT_CLKRUN_MODE 2
// power-state field inside the power management data register
`define BRC_PS_LSB 0
`define BRC_PS_MSB 1

// ------------------------------------------------------------
// power-state encodings
// ------------------------------------------------------------
`define BRC_PS_D0 2'h0
`define BRC_PS_D1 2'h1
`define BRC_PS_D2 2'h2
`define BRC_PS_D3HOT 2'h3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define BRC_RST_DSCLK_DIS 5'h00
`define BRC_RST_CLKRUN 3'h0
// capability word: D1/D2 not supported, version field 2
`define BRC_PM_CAP_VALUE 32'h0002_0001

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define BRC_CLK_MHZ 250
`define BRC_DS_RELEASE_US 100
`define BRC_CHIP_RESET_CYC 20
`define BRC_CLKRUN_HOLD_CYC 2'h2

`endif

// *** verilog/brc_delay_cnt.v ***
// brc_delay_cnt.v: down-counter that raises done after a loaded count.
// assumes: single clock, synchronous active-high reset, load has priority.
`timescale 1ns/1ps

module brc_delay_cnt #(
  parameter WIDTH = 16
) (
  input wire core_clk,
  input wire srst,
  input wire load,
  input wire [WIDTH-1:0] count,
  input wire run,
  output reg busy_ff,
  output reg done_ff
);

  reg [WIDTH-1:0] cnt_ff;

  always @(posedge core_clk) begin
    if (srst) begin
      cnt_ff <= {WIDTH{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (load) begin
      cnt_ff <= count;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (busy_ff && run) begin
      if (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end else begin
        done_ff <= 1'b0;
      end
      cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
    end else begin
      done_ff <= 1'b0;
    end
  end

endmodule // brc_delay_cnt

// *** verilog/brc_reset_power_clock.v ***
// brc_reset_power_clock.v: reset, power-state and clock control of a
// two-port bridge: power states, downstream clock gating, clock run,
// upstream/downstream/chip reset.
// assumes: a single-cycle configuration port on core_clk; pins from
// outside pass a two-flop synchroniser here; pin drivers outside use
// the enables (low = driving) produced here.
`timescale 1ns/1ps
`include "brc_regs.vh"

module brc_reset_power_clock #(
  parameter NUM_DSCLK = 5,
  parameter DS_RELEASE_CYC = `BRC_DS_RELEASE_US * `BRC_CLK_MHZ,
  parameter CNT_W = 16
) (
  input wire core_clk,
  input wire srst,
  input wire upstream_reset_n,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [31:0] cfg_wdata,
  input wire clock_gating_strap,
  input wire upstream_clock_run_n_in,
  input wire xfer_pending,
  input wire ds_clk_needed,
  input wire ds_bus_idle,
  input wire us_cycles_active,
  output reg [31:0] cfg_rdata_ff,
  output reg cfg_ack_ff,
  output reg [NUM_DSCLK-1:0] downstream_clock_outputs,
  output reg upstream_clock_run_n_out_ff,
  output reg upstream_clock_run_n_oe_n_ff,
  output reg downstream_reset_n_ff,
  output reg us_bus_float_ff,
  output reg ds_ctl_float_ff,
  output reg ds_ad_cbe_par_low_ff,
  output reg buffers_clear_ff,
  output reg internal_reset_ff,
  output reg ds_b2_allowed_ff
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg rstn_meta_ff, rstn_sync_ff;
  reg strap_meta_ff, strap_sync_ff;
  reg crun_meta_ff, crun_sync_ff;
  wire hard_rst = srst | ~rstn_sync_ff;

  // srst is the synchronised power-up reset; the pin reset is asserted
  // through the synchroniser, so its edges may come at any time
  always @(posedge core_clk) begin
    if (srst) begin
      rstn_meta_ff <= 1'b0;
      rstn_sync_ff <= 1'b0;
    end else begin
      rstn_meta_ff <= upstream_reset_n;
      rstn_sync_ff <= rstn_meta_ff;
    end
    strap_meta_ff <= clock_gating_strap;
    strap_sync_ff <= strap_meta_ff;
    crun_meta_ff <= upstream_clock_run_n_in;
    crun_sync_ff <= crun_meta_ff;
  end

  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  reg [1:0] pstate_ff;
  reg ds_reset_bit_ff;
  reg chip_reset_ff;
  reg [NUM_DSCLK-1:0] dsclk_dis_ff;
  reg [2:0] clkrun_ff;
  reg [4:0] chip_cnt_ff;
  reg [1:0] crun_cnt_ff;
  reg crun_prev_ff;
  reg soft_rst_ff;
  wire ds_cnt_busy;
  wire ds_cnt_done;
  reg ds_release_pending_ff;

  wire cfg_live = ~chip_reset_ff;
  wire wr_ok = cfg_wr & cfg_live;
  wire [1:0] req_ps = cfg_wdata[`BRC_PS_MSB:`BRC_PS_LSB];
  wire ps_wr = wr_ok && (cfg_addr == `BRC_OFF_PM_DATA);
  wire ps_legal = (req_ps == `BRC_PS_D0) || (req_ps == `BRC_PS_D3HOT);
  wire wake = ps_wr && ps_legal && (req_ps == `BRC_PS_D0) &&
    (pstate_ff == `BRC_PS_D3HOT);
  wire chip_wr = wr_ok && (cfg_addr == `BRC_OFF_CHIP_CTL) &&
    cfg_wdata[`BRC_BIT_CHIP_RESET];
  wire bctl_wr = wr_ok && (cfg_addr == `BRC_OFF_BRIDGE_CTL);
  // register reset covers hard reset, chip reset and the wake reset
  wire reg_rst = hard_rst | soft_rst_ff;

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  // D3cold is loss of power: only srst/pin reset brings us back to D0
  always @(posedge core_clk) begin
    if (reg_rst) begin
      pstate_ff <= `BRC_PS_D0;
    end else if (ps_wr && ps_legal) begin
      pstate_ff <= req_ps;
    end
    // D1/D2 requests fall through and leave the field untouched
  end

  // ------------------------------------------------------------
  // chip reset and wake reset
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (hard_rst) begin
      chip_reset_ff <= 1'b0;
      chip_cnt_ff <= 5'h00;
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wake | (chip_reset_ff &&
        (chip_cnt_ff == `BRC_CHIP_RESET_CYC - 1));
      if (chip_wr) begin
        chip_reset_ff <= 1'b1;
        chip_cnt_ff <= 5'h00;
      end else if (chip_reset_ff) begin
        if (chip_cnt_ff == `BRC_CHIP_RESET_CYC - 1) begin
          chip_reset_ff <= 1'b0;
        end
        chip_cnt_ff <= chip_cnt_ff + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reg_rst) begin
      dsclk_dis_ff <= `BRC_RST_DSCLK_DIS;
      clkrun_ff <= `BRC_RST_CLKRUN;
    end else if (wr_ok) begin
      if (cfg_addr == `BRC_OFF_DSCLK_CTL) begin
        dsclk_dis_ff <= cfg_wdata[NUM_DSCLK-1:0];
      end
      if (cfg_addr == `BRC_OFF_CLKRUN_CTL) begin
        clkrun_ff <= cfg_wdata[2:0];
      end
    end
  end

  // the wake reset leaves the downstream bus alone, so this bit only
  // follows hard reset, chip reset and software writes
  always @(posedge core_clk) begin
    if (hard_rst) begin
      ds_reset_bit_ff <= 1'b0;
    end else if (chip_wr | chip_reset_ff) begin
      ds_reset_bit_ff <= 1'b1;
    end else if (bctl_wr) begin
      ds_reset_bit_ff <= cfg_wdata[`BRC_BIT_DS_RESET];
    end
  end

  // ------------------------------------------------------------
  // downstream reset release delay
  // ------------------------------------------------------------
  wire ds_clear = bctl_wr && ds_reset_bit_ff &&
    ~cfg_wdata[`BRC_BIT_DS_RESET] && ~chip_reset_ff;

  brc_delay_cnt #(
    .WIDTH(CNT_W)
  ) u_release (
    .core_clk(core_clk),
    .srst(hard_rst),
    .load(ds_clear),
    .count(DS_RELEASE_CYC[CNT_W-1:0]),
    .run(~ds_reset_bit_ff),
    .busy_ff(ds_cnt_busy),
    .done_ff(ds_cnt_done)
  );

  always @(posedge core_clk) begin
    if (hard_rst) begin
      ds_release_pending_ff <= 1'b0;
    end else if (ds_reset_bit_ff) begin
      ds_release_pending_ff <= 1'b1;
    end else if (ds_cnt_done) begin
      ds_release_pending_ff <= 1'b0;
    end
  end

  wire ds_rst_active = hard_rst | ds_reset_bit_ff | ds_release_pending_ff |
    ds_cnt_busy;

  // ------------------------------------------------------------
  // clock run on the upstream bus
  // ------------------------------------------------------------
  wire keep_clock = clkrun_ff[`BRC_BIT_KEEP_CLK] | xfer_pending |
    ds_clk_needed | clkrun_ff[`BRC_BIT_DS_CLKRUN_EN];
  wire stop_req = crun_sync_ff & ~crun_prev_ff;

  always @(posedge core_clk) begin
    if (hard_rst) begin
      crun_prev_ff <= 1'b0;
      crun_cnt_ff <= 2'h0;
    end else begin
      crun_prev_ff <= crun_sync_ff;
      if (stop_req && keep_clock && crun_cnt_ff == 2'h0) begin
        crun_cnt_ff <= `BRC_CLKRUN_HOLD_CYC;
      end else if (crun_cnt_ff != 2'h0) begin
        crun_cnt_ff <= crun_cnt_ff - 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  wire d3hot = (pstate_ff == `BRC_PS_D3HOT);
  wire gate_pm = d3hot & strap_sync_ff;
  wire gate_idle = clkrun_ff[`BRC_BIT_CLKRUN_MODE] & ds_bus_idle &
    ~us_cycles_active;
  wire float_all = hard_rst | chip_reset_ff;

  always @(posedge core_clk) begin
    if (srst) begin
      downstream_clock_outputs <= {NUM_DSCLK{1'b1}};
      upstream_clock_run_n_out_ff <= 1'b1;
      upstream_clock_run_n_oe_n_ff <= 1'b1;
      downstream_reset_n_ff <= 1'b0;
      us_bus_float_ff <= 1'b1;
      ds_ctl_float_ff <= 1'b1;
      ds_ad_cbe_par_low_ff <= 1'b1;
      buffers_clear_ff <= 1'b1;
      internal_reset_ff <= 1'b1;
      ds_b2_allowed_ff <= 1'b0;
    end else begin
      // high level means the output runs; gated outputs park low
      downstream_clock_outputs <= (gate_pm | gate_idle) ?
        {NUM_DSCLK{1'b0}} : ~dsclk_dis_ff;
      upstream_clock_run_n_out_ff <= 1'b0;
      upstream_clock_run_n_oe_n_ff <= ~((crun_cnt_ff != 2'h0) &&
        ~float_all);
      downstream_reset_n_ff <= ~ds_rst_active;
      us_bus_float_ff <= float_all;
      ds_ctl_float_ff <= float_all | ds_rst_active;
      ds_ad_cbe_par_low_ff <= ds_rst_active;
      buffers_clear_ff <= ds_rst_active | reg_rst;
      internal_reset_ff <= reg_rst | chip_reset_ff;
      ds_b2_allowed_ff <= d3hot;
    end
  end

  // ------------------------------------------------------------
  // configuration read port
  // ------------------------------------------------------------
  // reads stay live under downstream reset, silent during chip reset
  always @(posedge core_clk) begin
    if (srst) begin
      cfg_rdata_ff <= 32'h0000_0000;
      cfg_ack_ff <= 1'b0;
    end else begin
      cfg_ack_ff <= (cfg_rd | cfg_wr) & cfg_live & ~hard_rst;
      cfg_rdata_ff <= 32'h0000_0000;
      if (cfg_rd) begin
        case (cfg_addr)
          `BRC_OFF_BRIDGE_CTL:
            cfg_rdata_ff[`BRC_BIT_DS_RESET] <= ds_reset_bit_ff;
          `BRC_OFF_CHIP_CTL:
            cfg_rdata_ff[`BRC_BIT_CHIP_RESET] <= chip_reset_ff;
          `BRC_OFF_CLKRUN_CTL: cfg_rdata_ff[2:0] <= clkrun_ff;
          `BRC_OFF_DSCLK_CTL: cfg_rdata_ff[NUM_DSCLK-1:0] <= dsclk_dis_ff;
          `BRC_OFF_PM_CAP: cfg_rdata_ff <= `BRC_PM_CAP_VALUE;
          `BRC_OFF_PM_DATA:
            cfg_rdata_ff[`BRC_PS_MSB:`BRC_PS_LSB] <= pstate_ff;
          default: cfg_rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // brc_reset_power_clock

// *** verif/brc_clock_resource_model.sv ***
// central resource model on the upstream clock-run line.
// assumes: line pulled high when nobody drives it low.
`timescale 1ns/1ps

module brc_clock_resource_model (
  input wire core_clk,
  input wire stop_req,
  input wire drive_out,
  input wire drive_oe_n,
  output wire clock_run_n
);
  reg hold_ff = 1'b1;
  reg req_q_ff = 1'b0;
  wire dev_low;

  assign dev_low = !drive_oe_n && !drive_out;
  // lets the line rise once per request, then holds it low again
  always @(posedge core_clk) begin
    req_q_ff <= stop_req;
    if (stop_req && !req_q_ff)
      hold_ff <= 1'b0;
    else if (!stop_req || dev_low)
      hold_ff <= 1'b1;
  end
  assign clock_run_n = (hold_ff || dev_low) ? 1'b0 : 1'b1;
endmodule // brc_clock_resource_model

// *** verif/brc_reset_power_clock_properties.sv ***
// port-level checks for the reset, power and clock-control block.
// assumes: bound to brc_reset_power_clock, one clock, srst sync high.
`timescale 1ns/1ps
`include "brc_regs.vh"

module brc_rpc_props (
  input wire core_clk,
  input wire srst,
  input wire upstream_reset_n,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [31:0] cfg_wdata,
  input wire upstream_clock_run_n_in,
  input wire xfer_pending,
  input wire cfg_ack_ff,
  input wire upstream_clock_run_n_oe_n_ff,
  input wire downstream_reset_n_ff,
  input wire us_bus_float_ff,
  input wire ds_ctl_float_ff,
  input wire ds_ad_cbe_par_low_ff,
  input wire buffers_clear_ff
);
  reg [4:0] chip_cnt_ff;
  wire chip_wr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  assign chip_wr = cfg_wr && cfg_addr == `BRC_OFF_CHIP_CTL &&
    cfg_wdata[`BRC_BIT_CHIP_RESET];
  // margin past the 20-cycle quiet window
  always @(posedge core_clk) begin
    if (srst)
      chip_cnt_ff <= 5'h00;
    else if (chip_wr)
      chip_cnt_ff <= 5'h1C;
    else if (chip_cnt_ff != 5'h00)
      chip_cnt_ff <= chip_cnt_ff - 5'h01;
  end

  pin_reset_a: assert property (
    $fell(upstream_reset_n) |-> ##[1:5] (!downstream_reset_n_ff
    && us_bus_float_ff && ds_ctl_float_ff))
    else $error("pin reset not followed");
  ds_float_a: assert property (
    $fell(downstream_reset_n_ff) |-> ##[0:1]
    (ds_ctl_float_ff && ds_ad_cbe_par_low_ff))
    else $error("ds bus not parked in reset");
  ds_buf_a: assert property (
    $fell(downstream_reset_n_ff) |->
    ($past(buffers_clear_ff) or ##[0:1] buffers_clear_ff))
    else $error("buffers not cleared");
  chip_quiet_a: assert property (
    chip_wr |-> ##2 !cfg_ack_ff [*8])
    else $error("answer during chip reset");
  chip_ds_a: assert property (
    chip_wr |-> ##[1:4] (!downstream_reset_n_ff && us_bus_float_ff))
    else $error("chip reset effects missing");
  ack_in_dsrst_a: assert property (
    (cfg_wr || cfg_rd) && !downstream_reset_n_ff && upstream_reset_n
    && chip_cnt_ff == 5'h00 |=> cfg_ack_ff)
    else $error("no answer under ds reset");
  clkrun_two_a: assert property (
    $fell(upstream_clock_run_n_oe_n_ff) |->
    ##1 !upstream_clock_run_n_oe_n_ff ##1 upstream_clock_run_n_oe_n_ff)
    else $error("clock-run drive not two cycles");
  clkrun_keep_a: assert property (
    $rose(upstream_clock_run_n_in) && xfer_pending |->
    ##[1:6] !upstream_clock_run_n_oe_n_ff)
    else $error("clock stop not refused");
endmodule // brc_rpc_props

bind brc_reset_power_clock brc_rpc_props u_props (
  .core_clk(core_clk), .srst(srst), .upstream_reset_n(upstream_reset_n),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .xfer_pending(xfer_pending),
  .upstream_clock_run_n_in(upstream_clock_run_n_in),
  .cfg_ack_ff(cfg_ack_ff), .ds_ctl_float_ff(ds_ctl_float_ff),
  .upstream_clock_run_n_oe_n_ff(upstream_clock_run_n_oe_n_ff),
  .downstream_reset_n_ff(downstream_reset_n_ff),
  .us_bus_float_ff(us_bus_float_ff), .buffers_clear_ff(buffers_clear_ff),
  .ds_ad_cbe_par_low_ff(ds_ad_cbe_par_low_ff));

// *** verif/brc_reset_power_clock_tb_top.sv ***
// self-checking bench for the reset, power and clock-control block.
// assumes: central resource model drives the clock-run line.
`timescale 1ns/1ps

module brc_reset_power_clock_tb_top;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d, m, e;
  } brc_row_t;
  localparam DSR = 20;
  logic core_clk, srst, upstream_reset_n, cfg_wr, cfg_rd, strap, xfer;
  logic need, stop_req, ack, oe_n, run_out, dsr_n, usf, dsf, adl, ok;
  logic bclr, ir, b2, ir_seen, idle, busy;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, rdata, q;
  logic [4:0] clks;
  wire clkrun_line;
  integer fails, check_count, i, k;
  brc_row_t rows [0:6];

  brc_reset_power_clock #(.DS_RELEASE_CYC(DSR)) DUT (
    .core_clk(core_clk), .srst(srst), .upstream_reset_n(upstream_reset_n),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .clock_gating_strap(strap),
    .upstream_clock_run_n_in(clkrun_line), .xfer_pending(xfer),
    .ds_clk_needed(need), .ds_bus_idle(idle), .us_cycles_active(busy),
    .cfg_rdata_ff(rdata), .cfg_ack_ff(ack),
    .downstream_clock_outputs(clks), .upstream_clock_run_n_out_ff(run_out),
    .upstream_clock_run_n_oe_n_ff(oe_n), .downstream_reset_n_ff(dsr_n),
    .us_bus_float_ff(usf), .ds_ctl_float_ff(dsf),
    .ds_ad_cbe_par_low_ff(adl), .buffers_clear_ff(bclr),
    .internal_reset_ff(ir), .ds_b2_allowed_ff(b2));
  brc_clock_resource_model model (.core_clk(core_clk),
    .stop_req(stop_req), .drive_out(run_out), .drive_oe_n(oe_n),
    .clock_run_n(clkrun_line));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (ir === 1'b1) ir_seen <= 1'b1;
  initial begin
    repeat (4000) @(posedge core_clk);
    fails = fails + 1;
    wrap_up;
  end

  // -------------
  // shared tasks
  // -------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count = check_count + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // one strobe, then up to four cycles for the answer
  task cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_addr <= a;
    cfg_wdata <= d;
    ok = 1'b0;
    q = 32'h0;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge core_clk);
      if (i == 0) begin
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
      end
      #1;
      if (!ok && ack === 1'b1) begin
        ok = 1'b1;
        q = rdata;
      end
    end
  endtask
  task pause(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // -------------
  // main sequence
  // -------------
  initial begin
    fails = 0;
    check_count = 0;
    {srst, upstream_reset_n, strap} = 3'h7;
    {cfg_wr, cfg_rd, xfer, need, stop_req, ir_seen} = 6'h00;
    {idle, busy} = 2'h2;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0;
    rows[0] = '{1'b0, 8'hDC, 0, 32'hFFFFFFFF, 32'h00020001};
    rows[1] = '{1'b1, 8'h68, 32'h0A, 32'h1F, 32'h0A};
    rows[2] = '{1'b1, 8'h58, 32'h7, 32'h7, 32'h7};
    rows[3] = '{1'b1, 8'h58, 32'h0, 32'h7, 32'h0};
    rows[4] = '{1'b1, 8'hE0, 32'h1, 32'h3, 32'h0};
    rows[5] = '{1'b1, 8'hE0, 32'h2, 32'h3, 32'h0};
    rows[6] = '{1'b1, 8'h3C, 32'h0, 32'h00400000, 32'h0};
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    pause(8);
    chk("reset outputs", 32'h13F, {dsr_n, usf, dsf, oe_n, clks});
    chk("idle drivers", 32'h0, {run_out, ir, bclr});
    $display("reset test done");
    for (k = 0; k < 7; k = k + 1) begin
      if (rows[k].w)
        cfg(1'b1, rows[k].a, rows[k].d);
      cfg(1'b0, rows[k].a, 32'h0);
      chk("row read", rows[k].e, q & rows[k].m);
    end
    chk("enabled clocks", 32'h15, clks);
    cfg(1'b1, 8'h58, 32'h4);
    pause(2);
    chk("idle gating", 32'h0, clks);
    @(posedge core_clk);
    busy <= 1'b1;
    pause(3);
    chk("us busy keeps clocks", 32'h15, clks);
    @(posedge core_clk);
    busy <= 1'b0;
    idle <= 1'b0;
    pause(3);
    chk("ds busy keeps clocks", 32'h15, clks);
    @(posedge core_clk);
    idle <= 1'b1;
    cfg(1'b1, 8'h58, 32'h0);
    $display("register test done");
    cfg(1'b1, 8'hE0, 32'h3);
    pause(4);
    chk("gated clocks", 32'h20, {b2, clks});
    ir_seen = 1'b0;
    cfg(1'b1, 8'hE0, 32'h0);
    pause(8);
    chk("wake", 32'h7F, {ir_seen, dsr_n, clks});
    cfg(1'b0, 8'h68, 32'h0);
    chk("wake clears regs", 32'h0, q & 32'h1F);
    @(posedge core_clk);
    strap <= 1'b0;
    cfg(1'b1, 8'hE0, 32'h3);
    pause(4);
    chk("strap blocks gating", 32'h1F, clks);
    cfg(1'b1, 8'hE0, 32'h0);
    pause(8);
    $display("power test done");
    cfg(1'b1, 8'h3C, 32'h00400000);
    chk("ds reset on", 32'h7, {dsr_n, dsf, adl, bclr});
    cfg(1'b0, 8'h58, 32'h0);
    chk("answer in ds reset", 32'h1, ok);
    cfg(1'b1, 8'h3C, 32'h0);
    pause(6);
    chk("release delayed", 32'h0, dsr_n);
    pause(DSR);
    chk("released", 32'h1, dsr_n);
    $display("ds reset test done");
    cfg(1'b1, 8'h40, 32'h1);
    cfg(1'b0, 8'h58, 32'h0);
    chk("quiet in chip reset", 32'h0, ok);
    pause(20);
    cfg(1'b0, 8'h40, 32'h0);
    chk("chip bit cleared", 32'h2, {ok, q[0]});
    cfg(1'b0, 8'h3C, 32'h0);
    chk("ds bit set", 32'h2, {q[22], dsr_n});
    cfg(1'b1, 8'h3C, 32'h0);
    pause(DSR + 10);
    chk("ds released", 32'h1, dsr_n);
    $display("chip reset test done");
    // cases 0..3 each hold one keep condition, case 4 none
    for (k = 0; k < 5; k = k + 1) begin
      cfg(1'b1, 8'h58, (k == 2) ? 32'h1 : (k == 3) ? 32'h2 : 32'h0);
      @(posedge core_clk);
      xfer <= (k == 0);
      need <= (k == 1);
      stop_req <= 1'b1;
      ok = 1'b0;
      for (i = 0; i < 12; i = i + 1) begin
        pause(1);
        if (oe_n === 1'b0)
          ok = 1'b1;
      end
      chk("clock kept", k < 4, ok);
      chk("line level", k > 3, clkrun_line);
      @(posedge core_clk);
      stop_req <= 1'b0;
      pause(4);
    end
    @(posedge core_clk);
    xfer <= 1'b0;
    need <= 1'b0;
    $display("clock run test done");
    cfg(1'b1, 8'h68, 32'h3);
    @(posedge core_clk);
    #1.3 upstream_reset_n = 1'b0;
    pause(6);
    chk("pin reset", 32'h3, {dsr_n, usf, dsf});
    #0.9 upstream_reset_n = 1'b1;
    pause(10);
    cfg(1'b0, 8'h68, 32'h0);
    chk("pin reset regs", 32'h20, {dsr_n, q[4:0]});
    $display("pin reset test done");
    wrap_up;
  end
endmodule // brc_reset_power_clock_tb_top
